// >>> logic/ppc_regs.svh
/*
 Constants of the port pin control block: reset values, package codes, widths.
 Assumes inclusion by its bare name from the package or design files.
*/
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

// Pin count and reset values
`define PPC_NUM_PINS 8
`define PPC_CTRL_RST 8'h00
`define PPC_FLAG_RST 8'h00

// Package codes and width
`define PPC_PKG_W 3
`define PPC_PKG_20PIN 3'h1
`define PPC_PKG_DEFAULT 3'h0

// Reroute select width
`define PPC_REROUTE_W 2

`endif

// >>> logic/ppc_pkg.sv
/*
 Types of the port pin control block.
 Assumes ppc_regs.svh is on the include path.
*/
`include "ppc_regs.svh"

package ppc_pkg;

	// Per-pin drive result
	typedef struct packed {
		logic out;
		logic oe;
		logic pull_up;
		logic pull_down;
	} ppc_drive_t;

	// Edge detector states
	typedef enum logic [1:0] {
		PPC_IDLE,
		PPC_ARMED
	} ppc_state_t;

endpackage

// >>> logic/ppc_pin.sv
/*
 One pin slice: priority select of functions, open-drain drive and pulls.
 Assumes the caller supplies function enables ordered low to high priority.
*/
`timescale 1ns/1ps

module ppc_pin #(
	parameter int NFUNC = 3
) (
	// Function sources, index 0 is the port function
	input wire logic [NFUNC-1:0] func_en,
	input wire logic [NFUNC-1:0] func_out,
	input wire logic [NFUNC-1:0] func_oe,
	// Pin controls
	input wire logic open_drain_output_select,
	input wire logic pull_enable_bit,
	input wire logic pull_polarity_select,
	// Result
	output ppc_pkg::ppc_drive_t drive
);

	////////////////////////////////////////////////////////////////////////
	// Highest enabled function wins; port function always available
	logic [$clog2(NFUNC+1)-1:0] sel;
	always_comb begin
		sel = '0;
		for (int i = 1; i < NFUNC; i++) begin
			if (func_en[i]) begin
				sel = ($clog2(NFUNC+1))'(i); // [R8]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wired-or drive: high level released instead of driven
	wire logic sel_out = func_out[sel];
	wire logic sel_oe = func_oe[sel];
	assign drive.out = sel_out;
	assign drive.oe = sel_oe & ~(open_drain_output_select & sel_out); // [R1]
	// Pull device chosen by the shared polarity bit
	assign drive.pull_up = pull_enable_bit & ~pull_polarity_select; // [R5]
	assign drive.pull_down = pull_enable_bit & pull_polarity_select; // [R5]

endmodule

// >>> logic/ppc_top.sv
/*
 Port pin control: per-pin drive, pin interrupt flags with edge select,
 shared-pin priority, reroute of peripheral signals and package code.
 Assumes pins arrive asynchronously and controls come from the same clock.
*/
// Contract
// R1 - Wired-or bit set on an output pin disables its high-side drive.
// R2 - Pin interrupt request raised only when flag and enable bit are both set.
// R3 - Valid edge on an interrupt pin sets a sticky flag.
// R4 - Polarity bit picks rising or falling edge as the valid event.
// R5 - With pull enabled, polarity bit picks pullup or pulldown.
// R6 - Reroute control moves peripheral signals, only in 20-pin package.
// R7 - Factory package code held and decides active routing.
// R8 - Shared pin goes to highest enabled function; port function is lowest.
// R9 - Software clears a flag by writing one; zero leaves it.
`timescale 1ns/1ps

`include "ppc_regs.svh"

module ppc_top #(
	parameter int NPINS = `PPC_NUM_PINS,
	parameter int NFUNC = 3,
	parameter logic [`PPC_PKG_W-1:0] PKG_CODE = `PPC_PKG_DEFAULT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pin side
	input wire logic [NPINS-1:0] pin_in,
	output logic [NPINS-1:0] pin_out,
	output logic [NPINS-1:0] pin_oe,
	output logic [NPINS-1:0] pin_pull_up,
	output logic [NPINS-1:0] pin_pull_down,
	// Port function controls
	input wire logic [NPINS-1:0] port_dir_out,
	input wire logic [NPINS-1:0] port_data,
	input wire logic [NPINS-1:0] open_drain_output_select,
	input wire logic [NPINS-1:0] pull_enable_bit,
	input wire logic [NPINS-1:0] pull_polarity_select,
	// Peripheral functions, NFUNC-1 per pin in priority order
	input wire logic [NPINS-1:0][NFUNC-2:0] periph_en,
	input wire logic [NPINS-1:0][NFUNC-2:0] periph_out,
	input wire logic [NPINS-1:0][NFUNC-2:0] periph_oe,
	// Reroute
	input wire logic [`PPC_REROUTE_W-1:0] pin_reroute_select,
	output logic [`PPC_REROUTE_W-1:0] reroute_active,
	// Package code
	output logic [`PPC_PKG_W-1:0] package_code_reg,
	// Interrupts
	input wire logic [NPINS-1:0] pin_irq_mask,
	input wire logic [NPINS-1:0] flag_clear_wr,
	output logic [NPINS-1:0] pin_irq_flag,
	output logic pin_irq
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and edge history
	logic [NPINS-1:0] sync1_r, sync2_r, prev_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r <= '0;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Edge select: polarity low falling, high rising
	wire logic [NPINS-1:0] rise = sync2_r & ~prev_r;
	wire logic [NPINS-1:0] fall = ~sync2_r & prev_r;
	wire logic [NPINS-1:0] valid_evt = pin_irq_mask &
		((pull_polarity_select & rise) | (~pull_polarity_select & fall)); // [R4]

	////////////////////////////////////////////////////////////////////////
	// Sticky flags, set wins over write-one clear
	logic [NPINS-1:0] flag_r, flag_nxt;
	assign flag_nxt = (flag_r & ~flag_clear_wr) | valid_evt; // [R3] [R9]
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_r <= `PPC_FLAG_RST;
		end else begin
			flag_r <= flag_nxt;
		end
	end
	assign pin_irq_flag = flag_r;
	assign pin_irq = |(flag_r & pin_irq_mask); // [R2]

	////////////////////////////////////////////////////////////////////////
	// Package code latched after reset release
	logic [`PPC_PKG_W-1:0] pkg_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pkg_r <= `PPC_PKG_DEFAULT;
		end else begin
			pkg_r <= PKG_CODE; // [R7]
		end
	end
	assign package_code_reg = pkg_r;
	wire logic is_20pin = (pkg_r == `PPC_PKG_20PIN);
	assign reroute_active = is_20pin ? pin_reroute_select : '0; // [R6]

	////////////////////////////////////////////////////////////////////////
	// Per-pin slices; reroute bit 0 swaps all peripheral functions of pins 0 and 1
	ppc_pkg::ppc_drive_t drv [NPINS];
	genvar g;
	generate
		for (g = 0; g < NPINS; g++) begin : g_pin
			localparam int SRC = (g < 2) ? (1 - g) : g;
			logic [NFUNC-1:0] f_en, f_out, f_oe;
			wire logic swap = reroute_active[0] && (g < 2); // [R6]
			assign f_en = {periph_en[swap ? SRC : g], 1'b1};
			assign f_out = {periph_out[swap ? SRC : g], port_data[g]};
			assign f_oe = {periph_oe[swap ? SRC : g], port_dir_out[g]};
			ppc_pin #(.NFUNC(NFUNC)) u_pin (
				.func_en(f_en),
				.func_out(f_out),
				.func_oe(f_oe),
				.open_drain_output_select(open_drain_output_select[g]),
				.pull_enable_bit(pull_enable_bit[g]),
				.pull_polarity_select(pull_polarity_select[g]),
				.drive(drv[g])
			);
			assign pin_out[g] = drv[g].out;
			assign pin_oe[g] = drv[g].oe;
			assign pin_pull_up[g] = drv[g].pull_up;
			assign pin_pull_down[g] = drv[g].pull_down;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Checks
	flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		|valid_evt |=> |pin_irq_flag) // [R3]
		else $error("flag not set on valid edge");
	rise_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pin_irq_mask[0] && pull_polarity_select[0] && rise[0]) |=> pin_irq_flag[0]) // [R4]
		else $error("rising edge missed");
	fall_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
		(pull_polarity_select[0] && fall[0] && !flag_r[0]) |=> !pin_irq_flag[0]) // [R4]
		else $error("wrong edge flagged");
	flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		(flag_r[0] && !flag_clear_wr[0]) |=> flag_r[0]) // [R9]
		else $error("flag lost without clear");
	flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		(flag_clear_wr[0] && !valid_evt[0]) |=> !flag_r[0]) // [R9]
		else $error("flag not cleared");
	irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		pin_irq |-> |(pin_irq_flag & pin_irq_mask)) // [R2]
		else $error("irq without enabled flag");
	wired_or_a: assert property (@(posedge clk) disable iff (!rst_n)
		(open_drain_output_select[0] && pin_out[0]) |-> !pin_oe[0]) // [R1]
		else $error("high side driven in wired-or");
	pull_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(pin_pull_up[0] && pin_pull_down[0])) // [R5]
		else $error("both pulls on");
	reroute_pkg_a: assert property (@(posedge clk) disable iff (!rst_n)
		!is_20pin |-> (reroute_active == '0)) // [R6]
		else $error("reroute outside 20-pin package");
	pkg_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n) |-> package_code_reg == PKG_CODE) // [R7]
		else $error("package code wrong");
	prio_a: assert property (@(posedge clk) disable iff (!rst_n)
		(periph_en[0][NFUNC-2] && !reroute_active[0]) |-> pin_out[0] == periph_out[0][NFUNC-2]) // [R8]
		else $error("priority broken");

	cov_irq_c: cover property (@(posedge clk) disable iff (!rst_n) pin_irq);
	cov_clear_c: cover property (@(posedge clk) disable iff (!rst_n)
		flag_r[0] ##1 !flag_r[0]);
	cov_race_c: cover property (@(posedge clk) disable iff (!rst_n)
		flag_clear_wr[0] && valid_evt[0]);
	cov_reroute_c: cover property (@(posedge clk) disable iff (!rst_n) reroute_active[0]);

endmodule

// >>> test/ppc_board.sv
/*
 Board model on the far side of the port pins: resolves each pin level.
 Assumes one bus clock; a pin with no driver and no pull floats and toggles.
*/
`timescale 1ns/1ps

module ppc_board #(
	parameter int N = 8
) (
	// Clock
	input wire logic clk,
	// Device side
	input wire logic [N-1:0] pin_out,
	input wire logic [N-1:0] pin_oe,
	input wire logic [N-1:0] pin_pull_up,
	input wire logic [N-1:0] pin_pull_down,
	// Board drivers
	input wire logic [N-1:0] ext_en,
	input wire logic [N-1:0] ext_val,
	// Resolved level
	output logic [N-1:0] pin_in
);
	logic [N-1:0] last_r;

	// Last level, so a floating pin never settles
	always_ff @(posedge clk) begin
		last_r <= pin_in;
	end

	// Device drive, then board, then pulls, else float
	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pin_pull_up[i] | pin_pull_down[i])
				pin_in[i] = pin_pull_up[i];
			else
				pin_in[i] = !(last_r[i] === 1'b1); // Float starts high after power-up
		end
	end
endmodule

// >>> test/testbench.sv
/*
 Self-checking bench of the port pin control block.
 Assumes ppc_regs.svh on the include path and a 20-pin package code.
*/
`timescale 1ns/1ps
`include "ppc_regs.svh"

module testbench;
	localparam int N = 8;
	logic clk, rst_n, irq;
	logic [N-1:0] pin_in, pin_out, pin_oe, pu, pd, dir, dat, wom, pe, ps;
	logic [N-1:0] mask, clr, flag, ext_en, ext_val, pm;
	logic [N-1:0][1:0] p_en, p_out, p_oe;
	logic [1:0] rsel, ract;
	logic [2:0] pkg;
	logic [15:0] r;
	int err_total, cmp_count, k;
	logic ex;

	ppc_top #(.PKG_CODE(`PPC_PKG_20PIN)) ppc_top_i (.clk(clk), .rst_n(rst_n),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pu),
		.pin_pull_down(pd), .port_dir_out(dir), .port_data(dat),
		.open_drain_output_select(wom), .pull_enable_bit(pe),
		.pull_polarity_select(ps), .periph_en(p_en), .periph_out(p_out),
		.periph_oe(p_oe), .pin_reroute_select(rsel), .reroute_active(ract),
		.package_code_reg(pkg), .pin_irq_mask(mask), .flag_clear_wr(clr),
		.pin_irq_flag(flag), .pin_irq(irq));
	ppc_board ppc_board_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pull_up(pu), .pin_pull_down(pd), .ext_en(ext_en),
		.ext_val(ext_val), .pin_in(pin_in));

	// Clock
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end

	// Compare and verdict
	task chk(input string nm, input logic [N-1:0] e, input logic [N-1:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task finish_test;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Expected {oe, out}; pm marks pins left to the pulls
	function automatic logic [15:0] exp_drv();
		logic [N-1:0] o, e;
		int s;
		for (int i = 0; i < N; i++) begin
			s = (rsel[0] && i < 2) ? 1 - i : i;
			o[i] = dat[i];
			e[i] = dir[i];
			for (int f = 0; f < 2; f++)
				if (p_en[s][f]) begin
					o[i] = p_out[s][f];
					e[i] = p_oe[s][f];
				end
			pm[i] = ~(dir[i] | (|p_en[s]));
			e[i] = e[i] & ~(wom[i] & o[i]);
		end
		return {e, o};
	endfunction

	// One pin edge: start level, edge, flag, clears
	task irq_case(input int i, input logic pol, input logic en, input logic rise);
		ext_val[i] = ~rise;
		cyc(4);
		clr = '1;
		cyc(1);
		clr = '0;
		mask = en ? N'(1 << i) : '0;
		ps[i] = pol;
		cyc(1);
		ext_val[i] = rise;
		ex = en & (pol == rise);
		for (k = 0; k < 6 && (k < 4 || flag[i] !== ex); k++)
			cyc(1);
		chk("flag", N'(ex) << i, flag);
		chk("irq", N'(ex), N'(irq));
		if (k == 6 && flag[i] !== ex) begin
			err_total++;
			finish_test;
		end
		clr = ~N'(1 << i);
		cyc(1);
		clr = N'(1 << i);
		chk("flag keep", N'(ex) << i, flag);
		cyc(1);
		clr = '0;
		chk("flag clr", '0, flag);
	endtask

	// Main sequence
	initial begin
		void'($urandom(99492));
		rst_n = 0;
		{dir, dat, wom, pe, ps, mask, clr, ext_val} = '0;
		{p_en, p_out, p_oe, rsel} = '0;
		ext_en = '1;
		cyc(5);
		chk("flag rst", '0, flag);
		chk("irq rst", '0, N'(irq));
		rst_n = 1;
		cyc(2);
		chk("pkg", N'(`PPC_PKG_20PIN), N'(pkg));
		// Random drive, pulls and reroute; corner all-ones drive and pulls first
		for (int j = 0; j < 300; j++) begin
			{dir, dat, wom, pe, ps} = j ? {$urandom, 8'($urandom)} : '1;
			{p_en, p_out, p_oe} = j ? {$urandom, 16'($urandom)} : '1;
			{rsel, ext_en, ext_val} = 18'($urandom);
			cyc(1);
			r = exp_drv();
			chk("drive", r[15:8], pin_oe);
			chk("out", r[7:0], pin_out);
			chk("reroute", N'(rsel), N'(ract));
			chk("pullup", pe & ~ps, pu);
			chk("pulldn", pe & ps, pd);
		end
		{p_en, dir, pe, rsel, ps} = '0;
		ext_en = '1;
		for (int j = 0; j < 32; j++)
			irq_case(j % 8, j[3], j[4] | j[0], j[2]);
		finish_test;
	end
endmodule
